// >>> hw/ebtec_cfg.svh
// offsets, field positions, reset values and timing counts of the timer block
`ifndef EBTEC_CFG_SVH
`define EBTEC_CFG_SVH

// ****************************************************************
// register addresses
// ****************************************************************
`define EBTEC_ADDR_MODE0    16'hFF70
`define EBTEC_ADDR_SEL0     16'hFF71
`define EBTEC_CH_STRIDE     16'h0004
`define EBTEC_ADDR_COUNT0   16'hFF60
`define EBTEC_ADDR_MATCH0   16'hFF64

// ****************************************************************
// mode control register fields
// ****************************************************************
`define EBTEC_MODE_TCE      7
`define EBTEC_MODE_PWM      6
`define EBTEC_MODE_CASC     4
`define EBTEC_MODE_LVS      3
`define EBTEC_MODE_LVR      2
`define EBTEC_MODE_INV      1
`define EBTEC_MODE_TOE      0
`define EBTEC_MODE_MASK0    8'hC3
`define EBTEC_MODE_MASK     8'hD3

// ****************************************************************
// clock select codes, prescaler and counter limits, reset values
// ****************************************************************
`define EBTEC_SEL_RISE      3'h0
`define EBTEC_SEL_FALL      3'h1
`define EBTEC_SEL_TOP       3'h7
`define EBTEC_PRESC_FULL    6'h3F
`define EBTEC_MODE_RST      8'h00
`define EBTEC_SEL_RST       3'h0
`define EBTEC_COUNT_RST     8'h00
`define EBTEC_COUNT_TOP     8'hFF
`define EBTEC_MATCH_RST     8'h00

`endif

// >>> hw/ebtec_clk_sel.sv
// count clock selector: pin synchroniser, prescaler and read hold-off
`timescale 1ns/100ps
`include "ebtec_cfg.svh"

module ebtec_clk_sel
  import ebtec_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // control
  input  wire logic       enable_i,
  input  wire logic [2:0] sel_i,
  input  wire logic       hold_i,
  // event pin
  input  wire logic       event_pin_i,
  // count clock enable
  output logic            tick_o
);

  ebtec_sel_t st;
  ebtec_sel_t next_st;
  logic       raw;
  logic [5:0] mask;

  // ****************************************************************
  // tick generation
  // ****************************************************************
  always_comb
  begin
    next_st      = st;
    next_st.sync = {st.sync[1:0], event_pin_i};
    mask         = `EBTEC_PRESC_FULL >> (`EBTEC_SEL_TOP - sel_i);
    // edges are judged only between the second and third stages
    unique case (sel_i)
      `EBTEC_SEL_RISE: raw = st.sync[1] & ~st.sync[2];
      `EBTEC_SEL_FALL: raw = ~st.sync[1] & st.sync[2];
      default:         raw = ((st.presc & mask) == mask);
    endcase
    tick_o = 1'b0;
    if (!enable_i)
    begin
      // stopped stage keeps its prescaler cleared
      next_st.presc = 6'h00;
      next_st.pend  = 1'b0;
    end
    else
    begin
      next_st.presc = st.presc + 6'h01;
      if (hold_i)
        next_st.pend = raw | st.pend;
      else
      begin
        tick_o       = raw | st.pend;
        next_st.pend = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st.sync  <= 3'h0;
      st.presc <= 6'h00;
      st.pend  <= 1'b0;
    end
    else
      st <= next_st;
  end

endmodule

// >>> hw/ebtec_pkg.sv
// types shared by the timer block
package ebtec_pkg;

  // ****************************************************************
  // per-stage state and block state with read return
  // ****************************************************************
  typedef struct packed {
    logic [7:0] mode;
    logic [2:0] sel;
    logic [7:0] count;
    logic [7:0] match;
    logic       tff;
    logic       meq;
    logic       irq;
    logic       pout;
  } ebtec_chan_t;

  typedef struct packed {
    ebtec_chan_t [2:0] ch;
    logic [15:0]       rdata;
    logic              rvalid;
  } ebtec_state_t;

  // ****************************************************************
  // count clock selector state
  // ****************************************************************
  typedef struct packed {
    logic [2:0] sync;
    logic [5:0] presc;
    logic       pend;
  } ebtec_sel_t;

endpackage

// >>> hw/ebtec_top.sv
// three 8-bit timer/event counters with cascade pairing
//
// Function
// - three stages 50, 51, 52; 50 lacks cascade bit
// - read-only 8-bit counter, counts count clock
// - single modes four; cascade no PWM
// - cascade pairs only 50/51 and 51/52
// - 16-bit read of pair 50/51 supported
// - no 16-bit read for pair 51/52
// - counter read briefly holds count clock
// - counter clears: reset, enable off, match
// - either stage enable off clears pair
// - continuous compare; match raises interrupt, not PWM
// - match value 00H-FFH, writable while running
// - pair 50/51 compares 16 bits, both interrupts
// - pair 51/52 match raises 51 and 52 interrupts
// - match byte writes; 50/51 wide access
// - logic ignores match register reset value
// - each stage: own pin, mode, clock select
// - enable off stops, clears, kills prescaler
// - mode bit: clear-on-match or PWM
// - bit 4 of 51/52 selects cascade
`timescale 1ns/100ps
`include "ebtec_cfg.svh"

module ebtec_top
  import ebtec_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // processor memory access
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic [15:0] cpu_wdata_i,
  input  wire logic        cpu_wr_i,
  input  wire logic        cpu_rd_i,
  input  wire logic        cpu_wide_i,
  output logic      [15:0] cpu_rdata_o,
  output logic             cpu_rvalid_o,
  // event pins
  input  wire logic [2:0]  event_pin_i,
  // timer outputs and interrupts
  output logic      [2:0]  timer_out_pin_o,
  output logic      [2:0]  timer_out_en_n_o,
  output logic      [2:0]  match_irq_o
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rst_q;
  logic       rst_n;

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end

  assign rst_n = rst_q[1];

  // ****************************************************************
  // state and derived terms
  // ****************************************************************
  ebtec_state_t st;
  ebtec_state_t next_st;

  logic       pair01;
  logic       pair12;
  logic [2:0] tce;
  logic [2:0] run;
  logic [2:0] upper;
  logic [2:0] lower;
  logic [2:0] pwm_eff;
  logic [2:0] eq;
  logic [2:0] tick;
  logic [2:0] inc;
  logic [2:0] carry;
  logic       wide01;
  logic       wide12;
  logic       count_rd;
  logic [1:0] base [3];
  logic [2:0] own_eq;
  logic [2:0] clr_match;
  logic [2:0] match_ev;
  logic [2:0] pwm_act;
  logic [2:0] hit_mode;
  logic [2:0] hit_sel;
  logic [2:0] hit_count;
  logic [2:0] hit_match;
  logic [2:0] wr_mode;
  logic [2:0] wr_sel;
  logic [2:0] wr_match;
  logic [2:0] lv_set;
  logic [2:0] lv_clr;
  logic [7:0] mode_mask [3];
  logic       wide_count;
  logic       wide_match;

  // a set 51 cascade bit wins; 52 cannot then join, so no 24-bit chain
  assign pair01 = st.ch[1].mode[`EBTEC_MODE_CASC];
  assign pair12 = st.ch[2].mode[`EBTEC_MODE_CASC] & ~pair01;

  assign upper = {pair12, pair01, 1'b0};
  assign lower = {1'b0, pair12, pair01};

  // ****************************************************************
  // enables and pairing
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_stage
      assign tce[gi]     = st.ch[gi].mode[`EBTEC_MODE_TCE];
      // PWM is a single-mode function only
      assign pwm_eff[gi] = st.ch[gi].mode[`EBTEC_MODE_PWM] & ~upper[gi] & ~lower[gi];
      assign carry[gi]   = inc[gi] & (st.ch[gi].count == `EBTEC_COUNT_TOP);
      assign own_eq[gi]  = (st.ch[gi].count == st.ch[gi].match);

      ebtec_clk_sel u_clk_sel
      (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n),
        .enable_i    (tce[gi]),
        .sel_i       (st.ch[gi].sel),
        .hold_i      (count_rd),
        .event_pin_i (event_pin_i[gi]),
        .tick_o      (tick[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // address decode
  // ****************************************************************
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_decode
      assign hit_mode[gi]  = (cpu_addr_i == (`EBTEC_ADDR_MODE0 + 16'(gi) * `EBTEC_CH_STRIDE));
      assign hit_sel[gi]   = (cpu_addr_i == (`EBTEC_ADDR_SEL0 + 16'(gi) * `EBTEC_CH_STRIDE));
      assign hit_count[gi] = (cpu_addr_i == (`EBTEC_ADDR_COUNT0 + 16'(gi)));
      assign hit_match[gi] = (cpu_addr_i == (`EBTEC_ADDR_MATCH0 + 16'(gi)));
      assign wr_mode[gi]   = cpu_wr_i & hit_mode[gi];
      assign wr_sel[gi]    = cpu_wr_i & hit_sel[gi];
      assign wr_match[gi]  = cpu_wr_i & hit_match[gi];
      // the prohibited strobe pair 1/1 is left without effect
      assign lv_set[gi]    = wr_mode[gi]
                           & cpu_wdata_i[`EBTEC_MODE_LVS] & ~cpu_wdata_i[`EBTEC_MODE_LVR];
      assign lv_clr[gi]    = wr_mode[gi]
                           & ~cpu_wdata_i[`EBTEC_MODE_LVS] & cpu_wdata_i[`EBTEC_MODE_LVR];
      // only stages 51 and 52 own a cascade bit
      assign mode_mask[gi] = (gi == 0) ? `EBTEC_MODE_MASK0 : `EBTEC_MODE_MASK;
    end
  endgenerate

  // wide accesses exist only while 50 and 51 are joined
  assign wide_count = cpu_wide_i & pair01 & hit_count[0];
  assign wide_match = cpu_wide_i & pair01 & hit_match[0];

  // either stage enable being low stops and clears the whole pair
  assign run[0] = pair01 ? (tce[0] & tce[1]) : tce[0];
  assign run[1] = pair01 ? (tce[0] & tce[1])
                : pair12 ? (tce[1] & tce[2]) : tce[1];
  assign run[2] = pair12 ? (tce[1] & tce[2]) : tce[2];

  // upper stage counts on the lower stage wrapping
  assign inc[0] = tick[0] & run[0];
  assign inc[1] = pair01 ? carry[0] : (tick[1] & run[1]);
  assign inc[2] = pair12 ? carry[1] : (tick[2] & run[2]);

  // stage whose count clock drives each counter
  assign base[0] = 2'h0;
  assign base[1] = pair01 ? 2'h0 : 2'h1;
  assign base[2] = pair12 ? 2'h1 : 2'h2;

  // ****************************************************************
  // compare
  // ****************************************************************
  assign wide01 = ({st.ch[1].count, st.ch[0].count} == {st.ch[1].match, st.ch[0].match});
  assign wide12 = ({st.ch[2].count, st.ch[1].count} == {st.ch[2].match, st.ch[1].match});

  assign eq[0] = pair01 ? wide01 : own_eq[0];
  assign eq[1] = pair01 ? wide01
               : pair12 ? wide12 : own_eq[1];
  assign eq[2] = pair12 ? wide12 : own_eq[2];

  // any counter read freezes the count clocks for that cycle
  assign count_rd = cpu_rd_i & (|hit_count);

  // ****************************************************************
  // match events
  // ****************************************************************
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_event
      // clear-and-start follows the count clock of the pair's lower stage
      assign clr_match[gi] = inc[base[gi]] & eq[gi]
                           & ~st.ch[base[gi]].mode[`EBTEC_MODE_PWM] & ~pwm_eff[gi];
      // one event per equality, however long the count rests on it
      assign match_ev[gi]  = eq[gi] & run[gi] & ~st.ch[gi].meq;
      assign pwm_act[gi]   = run[gi] & (st.ch[gi].count < st.ch[gi].match);
    end
  endgenerate

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    next_st        = st;
    next_st.rvalid = cpu_rd_i;
    next_st.rdata  = 16'h0000;

    for (int i = 0; i < 3; i++)
    begin
      // counter
      if (!run[i])
        next_st.ch[i].count = `EBTEC_COUNT_RST;
      else if (clr_match[i])
        next_st.ch[i].count = `EBTEC_COUNT_RST;
      else if (inc[i])
        next_st.ch[i].count = st.ch[i].count + 8'h01;

      // match event on the rising edge of equality
      next_st.ch[i].meq = eq[i] & run[i];
      next_st.ch[i].irq = match_ev[i] & ~pwm_eff[i];
      if (match_ev[i] & ~pwm_eff[i] & st.ch[i].mode[`EBTEC_MODE_INV])
        next_st.ch[i].tff = ~st.ch[i].tff;

      // PWM: active while the free-running count is below the match value
      next_st.ch[i].pout = pwm_eff[i]
                         ? (pwm_act[i] ^ st.ch[i].mode[`EBTEC_MODE_INV])
                         : st.ch[i].tff;

      // processor writes
      if (wr_mode[i])
        next_st.ch[i].mode = cpu_wdata_i[7:0] & mode_mask[i];
      // set/reset strobes act once and are never stored
      if (lv_set[i])
        next_st.ch[i].tff = 1'b1;
      else if (lv_clr[i])
        next_st.ch[i].tff = 1'b0;
      if (wr_sel[i])
        next_st.ch[i].sel = cpu_wdata_i[2:0];
      if (wr_match[i])
        next_st.ch[i].match = cpu_wdata_i[7:0];

      // processor reads
      if (cpu_rd_i & hit_mode[i])
        next_st.rdata = {8'h00, st.ch[i].mode};
      if (cpu_rd_i & hit_sel[i])
        next_st.rdata = {13'h0000, st.ch[i].sel};
      if (cpu_rd_i & hit_count[i])
        next_st.rdata = {8'h00, st.ch[i].count};
      if (cpu_rd_i & hit_match[i])
        next_st.rdata = {8'h00, st.ch[i].match};
    end

    // wide match write and wide reads exist only for the 50/51 pair
    if (cpu_wr_i & wide_match)
      next_st.ch[1].match = cpu_wdata_i[15:8];
    if (cpu_rd_i & wide_count)
      next_st.rdata = {st.ch[1].count, st.ch[0].count};
    if (cpu_rd_i & wide_match)
      next_st.rdata = {st.ch[1].match, st.ch[0].match};
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 3; i++)
      begin
        st.ch[i].mode  <= `EBTEC_MODE_RST;
        st.ch[i].sel   <= `EBTEC_SEL_RST;
        st.ch[i].count <= `EBTEC_COUNT_RST;
        // nominal only: nothing relies on this value
        st.ch[i].match <= `EBTEC_MATCH_RST;
        st.ch[i].tff   <= 1'b0;
        st.ch[i].meq   <= 1'b0;
        st.ch[i].irq   <= 1'b0;
        st.ch[i].pout  <= 1'b0;
      end
      st.rdata  <= 16'h0000;
      st.rvalid <= 1'b0;
    end
    else
      st <= next_st;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign cpu_rdata_o  = st.rdata;
  assign cpu_rvalid_o = st.rvalid;

  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_out
      assign timer_out_pin_o[gi]  = st.ch[gi].pout;
      assign timer_out_en_n_o[gi] = ~st.ch[gi].mode[`EBTEC_MODE_TOE];
      assign match_irq_o[gi]      = st.ch[gi].irq;
    end
  endgenerate

endmodule

// >>> sim/ebtec_checker.sv
// port assertions for the timer block
`timescale 1ns/100ps
module ebtec_checker (
  // watched ports
  input wire logic        sys_clk_i,
  input wire logic        resetn_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic [15:0] cpu_wdata_i,
  input wire logic        cpu_wr_i,
  input wire logic        cpu_rd_i,
  input wire logic        cpu_wide_i,
  input wire logic [15:0] cpu_rdata_o,
  input wire logic        cpu_rvalid_o,
  input wire logic [2:0]  event_pin_i,
  input wire logic [2:0]  timer_out_pin_o,
  input wire logic [2:0]  timer_out_en_n_o,
  input wire logic [2:0]  match_irq_o
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  rd_answer_a: assert property (cpu_rd_i |=> cpu_rvalid_o)
    else $error("read not answered");
  valid_cause_a: assert property (cpu_rvalid_o |-> $past(cpu_rd_i))
    else $error("read valid without request");
  idle_zero_a: assert property (!cpu_rvalid_o |-> cpu_rdata_o == 16'h0000)
    else $error("read data not zero when idle");
  unmapped_zero_a: assert property (cpu_rd_i && cpu_addr_i == 16'hFF7F
    |=> cpu_rdata_o == 16'h0000) else $error("unmapped read not zero");
  byte_upper_a: assert property (cpu_rd_i && !cpu_wide_i
    |=> cpu_rdata_o[15:8] == 8'h00) else $error("byte read upper half set");
  mode_mask_a: assert property (cpu_rd_i && cpu_addr_i == 16'hFF70
    |=> (cpu_rdata_o & 16'hFF3C) == 16'h0000) else $error("mode read shows fixed bits");
  // a match is edge-detected, one request per equality, so a request never stretches
  irq_pulse_a: assert property ((match_irq_o & $past(match_irq_o)) == 3'h0)
    else $error("match request longer than one cycle");
  out_enable_a: assert property (cpu_wr_i && !cpu_wide_i && cpu_addr_i == 16'hFF70
    |=> timer_out_en_n_o[0] == !$past(cpu_wdata_i[0])) else $error("output enable wrong");
endmodule

bind ebtec_top ebtec_checker ebtec_checker_inst (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cpu_addr_i(cpu_addr_i),
  .cpu_wdata_i(cpu_wdata_i), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i),
  .cpu_wide_i(cpu_wide_i), .cpu_rdata_o(cpu_rdata_o), .cpu_rvalid_o(cpu_rvalid_o),
  .event_pin_i(event_pin_i), .timer_out_pin_o(timer_out_pin_o),
  .timer_out_en_n_o(timer_out_en_n_o), .match_irq_o(match_irq_o));

// >>> sim/ebtec_tb_top.sv
// self-checking bench for the timer block
`timescale 1ns/100ps
module ebtec_tb_top;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [15:0] cpu_addr_i = 16'h0000;
  logic [15:0] cpu_wdata_i = 16'h0000;
  logic        cpu_wr_i = 1'b0;
  logic        cpu_rd_i = 1'b0;
  logic        cpu_wide_i = 1'b0;
  logic [2:0]  event_pin_i = 3'h0;
  logic [15:0] cpu_rdata_o;
  logic        cpu_rvalid_o;
  logic [2:0]  timer_out_pin_o;
  logic [2:0]  timer_out_en_n_o;
  logic [2:0]  match_irq_o;
  int          err_count = 0;
  int          checks = 0;
  logic [15:0] irqs [3] = '{default: 16'h0000};
  logic [15:0] base [3];
  logic [15:0] rv;

  ebtec_top ebtec_top_inst (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cpu_addr_i(cpu_addr_i),
    .cpu_wdata_i(cpu_wdata_i), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i),
    .cpu_wide_i(cpu_wide_i), .cpu_rdata_o(cpu_rdata_o), .cpu_rvalid_o(cpu_rvalid_o),
    .event_pin_i(event_pin_i), .timer_out_pin_o(timer_out_pin_o),
    .timer_out_en_n_o(timer_out_en_n_o), .match_irq_o(match_irq_o));

  initial
  begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i)
    for (int i = 0; i < 3; i++)
      if (match_irq_o[i] === 1'b1)
        irqs[i] <= irqs[i] + 16'h0001;

  // ****
  // bus and pin drivers
  // ****
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
    @(posedge sys_clk_i);
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    cpu_wide_i <= w;
    cpu_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    cpu_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic w);
    @(posedge sys_clk_i);
    cpu_addr_i <= a;
    cpu_wide_i <= w;
    cpu_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    cpu_rd_i <= 1'b0;
    #1;
    chk("rvalid", 16'h0001, {15'h0000, cpu_rvalid_o});
    rv = cpu_rdata_o;
  endtask
  // pin edges are spaced well beyond the three-flop synchroniser
  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      @(posedge sys_clk_i);
      event_pin_i[idx] <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      event_pin_i[idx] <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
    end
    repeat (6) @(posedge sys_clk_i);
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_regs();
    for (int i = 0; i < 3; i++)
    begin
      rd(16'hFF60 + 16'(i), 1'b0);
      chk("count reset", 16'h0000, rv);
      rd(16'hFF70 + 16'(4 * i), 1'b0);
      chk("mode reset", 16'h0000, rv);
    end
    chk("en_n reset", 16'h0007, {13'h0, timer_out_en_n_o});
    wr(16'hFF60, 16'h0055, 1'b0);
    rd(16'hFF60, 1'b0);
    chk("count read only", 16'h0000, rv);
    rd(16'hFF7F, 1'b0);
    chk("unmapped", 16'h0000, rv);
    wr(16'hFF64, 16'h00FF, 1'b0);
    rd(16'hFF64, 1'b0);
    chk("match byte", 16'h00FF, rv);
    wr(16'hFF70, 16'h000B, 1'b0);
    rd(16'hFF70, 1'b0);
    chk("mode strobes", 16'h0003, rv);
    chk("en_n", 16'h0006, {13'h0, timer_out_en_n_o});
    wr(16'hFF70, 16'h0000, 1'b0);
  endtask
  task automatic t_events();
    wr(16'hFF70, 16'h0080, 1'b0);
    pulse(0, 5);
    rd(16'hFF60, 1'b0);
    chk("event count", 16'h0005, rv);
    wr(16'hFF70, 16'h0000, 1'b0);
    rd(16'hFF60, 1'b0);
    chk("stop clears", 16'h0000, rv);
  endtask
  task automatic t_match();
    base = irqs;
    wr(16'hFF65, 16'h0003, 1'b0);
    wr(16'hFF74, 16'h0080, 1'b0);
    pulse(1, 3);
    rd(16'hFF61, 1'b0);
    chk("count at match", 16'h0003, rv);
    chk("match irq", base[1] + 16'h0001, irqs[1]);
    pulse(1, 1);
    rd(16'hFF61, 1'b0);
    chk("clear on match", 16'h0000, rv);
    wr(16'hFF65, 16'h0001, 1'b0);
    pulse(1, 1);
    chk("rewrite running", base[1] + 16'h0002, irqs[1]);
    wr(16'hFF74, 16'h0000, 1'b0);
  endtask
  task automatic t_pwm();
    base = irqs;
    wr(16'hFF66, 16'h0002, 1'b0);
    wr(16'hFF78, 16'h00C1, 1'b0);
    repeat (3) @(posedge sys_clk_i);
    chk("pwm active", 16'h0001, {15'h0, timer_out_pin_o[2]});
    pulse(2, 3);
    chk("pwm inactive", 16'h0000, {15'h0, timer_out_pin_o[2]});
    chk("pwm no irq", base[2], irqs[2]);
    wr(16'hFF78, 16'h0000, 1'b0);
  endtask
  // divided count clock: match 4 at every second cycle gives one event per 10 cycles
  task automatic t_interval();
    base = irqs;
    wr(16'hFF71, 16'h0002, 1'b0);
    wr(16'hFF64, 16'h0004, 1'b0);
    wr(16'hFF70, 16'h0087, 1'b0);
    repeat (190) @(posedge sys_clk_i);
    wr(16'hFF70, 16'h0001, 1'b0);
    chk("interval irqs", base[0] + 16'h0013, irqs[0]);
    chk("square out", 16'h0001, {15'h0, timer_out_pin_o[0]});
    wr(16'hFF70, 16'h0000, 1'b0);
    wr(16'hFF71, 16'h0000, 1'b0);
  endtask
  task automatic t_casc01();
    base = irqs;
    wr(16'hFF74, 16'h0010, 1'b0);
    wr(16'hFF64, 16'h0101, 1'b1);
    wr(16'hFF74, 16'h0090, 1'b0);
    wr(16'hFF70, 16'h0080, 1'b0);
    pulse(0, 257);
    rd(16'hFF60, 1'b1);
    chk("wide count", 16'h0101, rv);
    rd(16'hFF64, 1'b1);
    chk("wide match", 16'h0101, rv);
    chk("irq lower", base[0] + 16'h0001, irqs[0]);
    chk("irq upper", base[1] + 16'h0001, irqs[1]);
    wr(16'hFF74, 16'h0010, 1'b0);
    rd(16'hFF60, 1'b1);
    chk("pair cleared", 16'h0000, rv);
    wr(16'hFF70, 16'h0000, 1'b0);
    wr(16'hFF74, 16'h0000, 1'b0);
  endtask
  task automatic t_casc12();
    base = irqs;
    wr(16'hFF65, 16'h0000, 1'b0);
    wr(16'hFF66, 16'h0001, 1'b0);
    wr(16'hFF78, 16'h0090, 1'b0);
    wr(16'hFF74, 16'h0080, 1'b0);
    pulse(1, 256);
    rd(16'hFF62, 1'b0);
    chk("upper byte", 16'h0001, rv);
    rd(16'hFF61, 1'b0);
    chk("lower byte", 16'h0000, rv);
    chk("pair irq", base[1] + 16'h0001, irqs[1]);
  endtask

  task automatic end_of_test();
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    end_of_test();
  end
  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    t_regs();
    t_events();
    t_match();
    t_pwm();
    t_casc01();
    t_casc12();
    t_interval();
    end_of_test();
  end
endmodule
